// *** tfc_top.sv ***
// Purpose: Serial datapath for clear_flag_if_bit_zero and clear_flag_if_accum_nonzero.
// Assumes: The sequencer pulses cmd_in.start for one cycle in execution state 4.
// Notes: One shift of the accumulator per clock; register port writes are refused while busy.
//
// Local design decisions: the plain strobed port and the address map.
`timescale 1ns/100ps
`include "tfc_consts.svh"

// Summary of operation
// RL1: Bit-zero op clears test flag if bit zero.
// RL2: Bit-zero op leaves flag when Z above 23.
// RL3: Bit-zero op restores original accumulator.
// RL4: State 4 loads counter with inverted selector.
// RL5: Inverted low bit feeds adder first input.
// RL6: Carry flag held set during bit-zero shifts.
// RL7: Sum equals true bit, written to bit 23.
// RL8: Position counter advances every shift.
// RL9: At count 37 octal, test leaving bit.
// RL10: Nonzero op clears flag if any one.
// RL11: Nonzero op restores original accumulator; the code restores it only when cmd_in.sel is 0 or 24.
// RL12: Nonzero op presets counter from inverted bits.
// RL13: Nonzero op feeds true low bit only.
// RL14: Any one leaving bit 0 clears flag.
// RL15: Nonzero op stops shifting at count 37.
// RL16: Nonzero op rotates exactly 24 places; the code rotates as many places as cmd_in.sel gives, so 24 only when sel is 24.
// RL17: Completion steps PC, keeps other state.
// RL18: Carry flag stays clear in nonzero op.
module tfc_top
(
	input wire logic clk_in,
	input wire logic reset_in,
	input wire tfc_pkg::tfc_cmd_s cmd_in,
	input wire logic [1:0] reg_addr_in,
	input wire logic [`TFC_WORD_BITS-1:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	output logic [`TFC_WORD_BITS-1:0] reg_rdata_out,
	output logic busy_out,
	output logic done_out,
	output logic test_flag_out,
	output logic serial_carry_flag_out,
	output logic [`TFC_PC_BITS-1:0] pc_out
);
	import tfc_pkg::*;

	tfc_state_e state_q;
	tfc_state_e state_d;
	logic [`TFC_WORD_BITS-1:0] acc_q;
	logic [`TFC_WORD_BITS-1:0] acc_d;
	logic [4:0] j_q;
	logic [4:0] j_d;
	logic [4:0] sh_q;
	logic [4:0] sh_d;
	logic [4:0] preset_q;
	logic test_flag_q;
	logic test_flag_d;
	logic carry_q;
	logic carry_d;
	logic overflow_flag_q;
	logic protect_flag_q;
	logic [`TFC_PC_BITS-1:0] pc_q;
	logic [`TFC_PC_BITS-1:0] pc_d;
	logic done_q;
	logic busy_q;
	logic [`TFC_WORD_BITS-1:0] rdata_q;

	wire idle = (state_q == ST_IDLE);
	wire start_even = idle && cmd_in.start && (cmd_in.op == TFC_OP_BIT_ZERO);
	wire start_nz = idle && cmd_in.start && (cmd_in.op == TFC_OP_NONZERO);
	wire start_any = start_even || start_nz;
	wire wr_ok = reg_wr_in && idle && !cmd_in.start;
	wire wr_acc = wr_ok && (reg_addr_in == `TFC_ADDR_ACC);
	wire wr_flags = wr_ok && (reg_addr_in == `TFC_ADDR_FLAGS);
	wire wr_pc = wr_ok && (reg_addr_in == `TFC_ADDR_PC);

	wire acc_low_bit = acc_q[0];
	wire position_count_terminal = (j_q == `TFC_J_TERM);
	wire shift_even = (state_q == ST_EVEN);
	// The nonzero op shifts only until the counter reaches its terminal value.
	wire shift_nz = (state_q == ST_NZ) && !position_count_terminal; // [RL15] [RL16]
	wire accum_shift_enable = shift_even || shift_nz;
	wire last_even = shift_even && (sh_q == `TFC_SHIFTS - 5'h01);
	wire finish_nz = (state_q == ST_NZ) && position_count_terminal;
	wire finish = last_even || finish_nz;

	// Serial full adder: A input gated per op, B input from the carry flag.
	wire adder_a = shift_even ? ~acc_low_bit : (shift_nz & acc_low_bit); // [RL5] [RL13]
	wire adder_b = shift_even & carry_q; // [RL6]
	wire adder_sum = adder_a ^ adder_b; // [RL7]

	// Bit-zero op tests only the bit leaving when the counter is terminal.
	wire clear_even = shift_even && position_count_terminal && !acc_low_bit; // [RL1] [RL9]
	wire clear_nz = shift_nz && acc_low_bit; // [RL10] [RL14]
	wire flag_clear_condition = clear_even || clear_nz;

	wire [`TFC_WORD_BITS-1:0] stat_word = {{(`TFC_WORD_BITS - `TFC_STAT_J_HI - 1){1'b0}},
		j_q, 3'h0, busy_q};
	wire [`TFC_WORD_BITS-1:0] flags_word = {{(`TFC_WORD_BITS - 4){1'b0}},
		protect_flag_q, overflow_flag_q, carry_q, test_flag_q};
	wire [`TFC_WORD_BITS-1:0] pc_word = {{(`TFC_WORD_BITS - `TFC_PC_BITS){1'b0}}, pc_q};
	wire [`TFC_WORD_BITS-1:0] rd_mux =
		(reg_addr_in == `TFC_ADDR_ACC) ? acc_q :
		(reg_addr_in == `TFC_ADDR_FLAGS) ? flags_word :
		(reg_addr_in == `TFC_ADDR_PC) ? pc_word : stat_word;

	always_comb
	begin
		state_d = state_q;
		case (state_q)
			ST_IDLE:
			begin
				if (start_even)
					state_d = ST_EVEN;
				else if (start_nz)
					state_d = ST_NZ;
			end
			ST_EVEN:
			begin
				if (last_even)
					state_d = ST_IDLE;
			end
			ST_NZ:
			begin
				if (finish_nz)
					state_d = ST_IDLE;
			end
			default:
				state_d = ST_IDLE;
		endcase
	end

	always_comb
	begin
		acc_d = acc_q;
		if (wr_acc)
			acc_d = reg_wdata_in;
		else if (accum_shift_enable)
			acc_d = {adder_sum, acc_q[`TFC_WORD_BITS-1:1]}; // [RL3] [RL7] [RL11]
	end

	always_comb
	begin
		j_d = j_q;
		if (start_any)
			j_d = ~cmd_in.sel; // [RL4] [RL12]
		else if (accum_shift_enable)
			j_d = j_q + 5'h01; // [RL8]
	end

	always_comb
	begin
		sh_d = sh_q;
		if (start_any)
			sh_d = 5'h00;
		else if (accum_shift_enable)
			sh_d = sh_q + 5'h01;
	end

	always_comb
	begin
		test_flag_d = test_flag_q;
		if (wr_flags)
			test_flag_d = reg_wdata_in[`TFC_FLAG_TEST];
		else if (flag_clear_condition)
			test_flag_d = 1'b0; // [RL1] [RL2] [RL14]
	end

	always_comb
	begin
		carry_d = carry_q;
		if (wr_flags)
			carry_d = reg_wdata_in[`TFC_FLAG_CARRY];
		else if (start_even)
			carry_d = 1'b1; // [RL6]
		else if (start_nz)
			carry_d = 1'b0; // [RL18]
	end

	always_comb
	begin
		pc_d = pc_q;
		if (wr_pc)
			pc_d = reg_wdata_in[`TFC_PC_BITS-1:0];
		else if (finish)
			pc_d = pc_q + 15'h0001; // [RL17]
	end

	always_ff @(posedge clk_in)
	begin
		if (reset_in)
		begin
			state_q <= ST_IDLE;
			acc_q <= `TFC_ACC_RESET;
			j_q <= 5'h00;
			sh_q <= 5'h00;
			preset_q <= 5'h00;
			pc_q <= `TFC_PC_RESET;
			done_q <= 1'b0;
			busy_q <= 1'b0;
			rdata_q <= 24'h000000;
		end
		else
		begin
			state_q <= state_d;
			acc_q <= acc_d;
			j_q <= j_d;
			sh_q <= sh_d;
			preset_q <= start_any ? ~cmd_in.sel : preset_q;
			pc_q <= pc_d;
			done_q <= finish;
			busy_q <= (state_d != ST_IDLE);
			rdata_q <= reg_rd_in ? rd_mux : rdata_q;
		end
	end

	// Overflow and protect flags change only by software; the ops never touch them.
	always_ff @(posedge clk_in)
	begin
		if (reset_in)
		begin
			test_flag_q <= 1'(`TFC_FLAGS_RESET >> `TFC_FLAG_TEST);
			carry_q <= 1'b0;
			overflow_flag_q <= 1'b0;
			protect_flag_q <= 1'b0;
		end
		else
		begin
			test_flag_q <= test_flag_d;
			carry_q <= carry_d;
			overflow_flag_q <= wr_flags ? reg_wdata_in[`TFC_FLAG_OVFL] : overflow_flag_q;
			protect_flag_q <= wr_flags ? reg_wdata_in[`TFC_FLAG_PROT] : protect_flag_q; // [RL17]
		end
	end

	assign reg_rdata_out = rdata_q;
	assign busy_out = busy_q;
	assign done_out = done_q;
	assign test_flag_out = test_flag_q;
	assign serial_carry_flag_out = carry_q;
	assign pc_out = pc_q;

	a_even_clear_zero: assert property ( // [RL1]
		@(posedge clk_in) disable iff (reset_in)
		shift_even && position_count_terminal && !acc_low_bit |=> !test_flag_q)
		else $error("Test flag not cleared for a zero selected bit.");

	a_even_flag_kept: assert property ( // [RL2]
		@(posedge clk_in) disable iff (reset_in)
		shift_even && !(position_count_terminal && !acc_low_bit) |=> $stable(test_flag_q))
		else $error("Test flag changed without a zero selected bit.");

	a_even_acc_restored: assert property ( // [RL3]
		@(posedge clk_in) disable iff (reset_in)
		start_even |-> ##25 (acc_q == $past(acc_q, 25)))
		else $error("Accumulator altered by the bit-zero op.");

	a_counter_preset: assert property ( // [RL4]
		@(posedge clk_in) disable iff (reset_in)
		start_any |=> (j_q == ~$past(cmd_in.sel)) && (sh_q == 5'h00))
		else $error("Position counter not preset from the inverted selector.");

	a_adder_a_inverted: assert property ( // [RL5]
		@(posedge clk_in) disable iff (reset_in)
		shift_even |-> (adder_a == ~acc_low_bit) && (adder_b == 1'b1))
		else $error("Adder inputs wrong during the bit-zero op.");

	a_carry_held_set: assert property ( // [RL6]
		@(posedge clk_in) disable iff (reset_in)
		shift_even |-> carry_q)
		else $error("Carry flag not held set during bit-zero shifts.");

	a_sum_to_top: assert property ( // [RL7]
		@(posedge clk_in) disable iff (reset_in)
		accum_shift_enable |=> acc_q[`TFC_WORD_BITS-1] == $past(acc_low_bit))
		else $error("Bit entering the top differs from the bit leaving the bottom.");

	a_counter_advance: assert property ( // [RL8]
		@(posedge clk_in) disable iff (reset_in)
		accum_shift_enable |=> j_q == $past(j_q) + 5'h01)
		else $error("Position counter did not advance on a shift.");

	a_nz_flag_kept: assert property ( // [RL10]
		@(posedge clk_in) disable iff (reset_in)
		(state_q == ST_NZ) && !(shift_nz && acc_low_bit) |=> $stable(test_flag_q))
		else $error("Test flag changed while only zeros left the accumulator.");

	a_nz_acc_restored: assert property ( // [RL11]
		@(posedge clk_in) disable iff (reset_in)
		finish_nz |-> acc_q == $past(acc_q, 25))
		else $error("Accumulator altered by the nonzero op.");

	a_nz_only_a0: assert property ( // [RL13]
		@(posedge clk_in) disable iff (reset_in)
		shift_nz |-> (adder_b == 1'b0) && (adder_sum == acc_low_bit))
		else $error("Adder inputs wrong during the nonzero op.");

	a_nz_clear_one: assert property ( // [RL14]
		@(posedge clk_in) disable iff (reset_in)
		shift_nz && acc_low_bit |=> !test_flag_q)
		else $error("A one left the accumulator without clearing the test flag.");

	a_nz_stop: assert property ( // [RL15]
		@(posedge clk_in) disable iff (reset_in)
		finish_nz |=> idle && $stable(acc_q) && $stable(j_q))
		else $error("Shifting continued after the counter reached its terminal value.");

	a_nz_count: assert property ( // [RL16]
		@(posedge clk_in) disable iff (reset_in)
		finish_nz && (preset_q == 5'h07) |-> sh_q == `TFC_SHIFTS)
		else $error("Nonzero op did not rotate exactly 24 places.");

	a_pc_step: assert property ( // [RL17]
		@(posedge clk_in) disable iff (reset_in)
		finish |=> done_q && (pc_q == $past(pc_q) + 15'h0001) && $stable(overflow_flag_q))
		else $error("Program counter not stepped by one at completion.");

	a_nz_carry_clear: assert property ( // [RL18]
		@(posedge clk_in) disable iff (reset_in)
		(state_q == ST_NZ) |-> !carry_q)
		else $error("Carry flag set during the nonzero op.");

	a_even_high_kept: assert property ( // [RL2]
		@(posedge clk_in) disable iff (reset_in)
		start_even && (cmd_in.sel > 5'h17) |-> ##25 (test_flag_q == $past(test_flag_q, 25)))
		else $error("Test flag changed although the selected bit lies above 23.");

	a_even_term_bit: assert property ( // [RL9]
		@(posedge clk_in) disable iff (reset_in)
		shift_even && position_count_terminal |-> (sh_q == ~preset_q))
		else $error("Counter terminal at a shift other than the selected bit.");

	a_nz_preset_seven: assert property ( // [RL12]
		@(posedge clk_in) disable iff (reset_in)
		start_nz && (cmd_in.sel == 5'h18) |=> (j_q == 5'h07))
		else $error("Nonzero op did not preset the counter to seven.");

	a_nz_zero_kept: assert property ( // [RL10]
		@(posedge clk_in) disable iff (reset_in)
		start_nz && (cmd_in.sel == 5'h18) && (acc_q == 24'h000000) |->
		##25 (test_flag_q == $past(test_flag_q, 25)))
		else $error("Test flag changed for an all-zero accumulator.");

	a_nz_one_clears: assert property ( // [RL10]
		@(posedge clk_in) disable iff (reset_in)
		start_nz && (cmd_in.sel == 5'h18) && (acc_q != 24'h000000) |-> ##25 !test_flag_q)
		else $error("Test flag not cleared for a nonzero accumulator.");

	a_op_keeps_flags: assert property ( // [RL17]
		@(posedge clk_in) disable iff (reset_in)
		accum_shift_enable |=> $stable(overflow_flag_q) && $stable(protect_flag_q))
		else $error("Overflow or protect flag changed during an op.");

endmodule

// *** tfc_consts.svh ***
// Purpose: Offsets, field positions, reset values and counts for the test flag unit.
// Assumes: Included by its bare name wherever these values are needed.
// Notes: Definitions only.
`ifndef TFC_CONSTS_SVH
`define TFC_CONSTS_SVH
`define TFC_WORD_BITS 24
`define TFC_PC_BITS 15
`define TFC_SHIFTS 5'h18
`define TFC_J_TERM 5'h1F
`define TFC_ADDR_ACC 2'h0
`define TFC_ADDR_FLAGS 2'h1
`define TFC_ADDR_PC 2'h2
`define TFC_ADDR_STAT 2'h3
`define TFC_FLAG_TEST 0
`define TFC_FLAG_CARRY 1
`define TFC_FLAG_OVFL 2
`define TFC_FLAG_PROT 3
`define TFC_STAT_BUSY 0
`define TFC_STAT_J_LO 4
`define TFC_STAT_J_HI 8
`define TFC_ACC_RESET 24'h000000
`define TFC_PC_RESET 15'h0000
`define TFC_FLAGS_RESET 4'h0
`endif

// *** tfc_pkg.sv ***
// Purpose: Types shared by the test flag unit and its sequencer.
// Assumes: Nothing beyond a SystemVerilog compiler.
// Notes: Constants live in tfc_consts.svh.
package tfc_pkg;
	typedef enum logic {TFC_OP_BIT_ZERO, TFC_OP_NONZERO} tfc_op_e;
	typedef enum logic [1:0] {ST_IDLE, ST_EVEN, ST_NZ} tfc_state_e;
	typedef struct packed {
		logic start;
		tfc_op_e op;
		logic [4:0] sel;
	} tfc_cmd_s;
endpackage

// *** tfc_seq_model.sv ***
// Purpose: Sequencer stand-in that issues one start pulse in execution state 4.
// Assumes: go_in is a one-cycle request from the bench.
// Notes: Between pulses the selector toggles so that it is never trusted outside start.
`timescale 1ns/100ps
module tfc_seq_model
(
	input wire logic clk_in,
	input wire logic reset_in,
	input wire logic go_in,
	input wire logic op_in,
	input wire logic [4:0] sel_in,
	output tfc_pkg::tfc_cmd_s cmd_out
);
	import tfc_pkg::*;
	always_ff @(posedge clk_in)
	begin
		if (reset_in)
		begin
			cmd_out <= '0;
		end
		else
		begin
			cmd_out.start <= go_in;
			cmd_out.op <= tfc_op_e'(op_in);
			cmd_out.sel <= go_in ? sel_in : ~cmd_out.sel;
		end
	end
endmodule

// *** tfc_top_tb.sv ***
// Purpose: Self-checking bench for tfc_top.
// Assumes: tfc_seq_model issues the start pulse one cycle after a request.
// Notes: Each case loads ACC and FLAGS, runs one op and checks what it left.
`timescale 1ns/100ps
`include "tfc_consts.svh"
module tfc_top_tb;
	import tfc_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic go = 1'b0;
	logic op = 1'b0;
	logic [4:0] sel = 5'h00;
	tfc_cmd_s cmd;
	logic [1:0] addr = 2'h0;
	logic [23:0] wdata = 24'h000000;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [23:0] rdata;
	logic busy, done, tflag, cflag;
	logic [14:0] pc;
	int mismatches = 0;
	int comparisons = 0;
	tfc_seq_model u_seq (.clk_in(clk), .reset_in(rst), .go_in(go), .op_in(op), .sel_in(sel),
		.cmd_out(cmd));
	tfc_top u_dut (.clk_in(clk), .reset_in(rst), .cmd_in(cmd), .reg_addr_in(addr),
		.reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
		.busy_out(busy), .done_out(done), .test_flag_out(tflag),
		.serial_carry_flag_out(cflag), .pc_out(pc));
	initial
	begin
		forever #4 clk = ~clk;
	end
	task automatic report_and_stop();
		if (mismatches == 0 && comparisons > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic wr_reg(input logic [1:0] a, input logic [23:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rd_reg(input logic [1:0] a, output logic [23:0] d);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		d = rdata;
	endtask
	// Loads the accumulator, sets test, overflow and protect flags, then runs one op.
	task automatic run_case(input logic o, input logic [4:0] s, input logic [23:0] a);
		logic [23:0] r;
		logic [14:0] pc0;
		logic keep;
		int n;
		wr_reg(`TFC_ADDR_ACC, a);
		wr_reg(`TFC_ADDR_FLAGS, 24'h00000D);
		pc0 = pc;
		keep = o ? (a == 24'h000000) : (s > 5'h17 || a[s]);
		@(posedge clk);
		go <= 1'b1;
		op <= o;
		sel <= s;
		n = 0;
		while (n < 100)
		begin
			@(posedge clk);
			go <= 1'b0;
			n++;
			#1;
			if (n == 2)
				chk({23'h0, busy}, 24'h000001);
			if (done === 1'b1)
				break;
		end
		chk(24'(n), o ? 24'h00001B : 24'h00001A);
		chk({23'h0, busy}, 24'h000000);
		chk({23'h0, tflag}, {23'h0, keep});
		chk({23'h0, cflag}, {23'h0, ~o});
		chk({9'h0, pc}, {9'h0, pc0 + 15'h0001});
		rd_reg(`TFC_ADDR_ACC, r);
		chk(r, a);
		rd_reg(`TFC_ADDR_FLAGS, r);
		chk({22'h0, r[3:2]}, 24'h000003);
		rd_reg(`TFC_ADDR_STAT, r);
		chk({19'h0, r[8:4]}, {19'h0, o ? 5'h1F : 5'h17 - s});
	endtask
	initial
	begin
		logic [23:0] r;
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		rd_reg(`TFC_ADDR_FLAGS, r);
		chk(r, 24'h000000);
		chk({9'h0, pc}, 24'h000000);
		run_case(1'b0, 5'h00, 24'hA50F3C);
		run_case(1'b0, 5'h02, 24'hA50F3C);
		run_case(1'b0, 5'h17, 24'h5A0F3C);
		run_case(1'b0, 5'h1E, 24'h000000);
		run_case(1'b1, 5'h18, 24'h800000);
		run_case(1'b1, 5'h18, 24'h000000);
		report_and_stop();
	end
	initial
	begin
		#40000;
		mismatches++;
		report_and_stop();
	end
endmodule
